//--- src/wdt_defines.svh
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define WDT_CTRL_OFFSET     12'h000
`define WDT_EVT_OFFSET      12'h004
`define WDT_MASK_OFFSET     12'h008
`define WDT_COUNT_OFFSET    12'h00C

// ---------------------------------------------------------------------------
// Control register field positions
// ---------------------------------------------------------------------------
`define WDT_UNLOCK_BIT      0
`define WDT_ENABLE_BIT      1
`define WDT_STATUS_BIT      2
`define WDT_RESP_BIT        3
`define WDT_SCALER_LSB      4
`define WDT_SCALER_MSB      7

// ---------------------------------------------------------------------------
// Event register field positions
// ---------------------------------------------------------------------------
`define WDT_EVT_TIMEOUT     0
`define WDT_EVT_RESET       1
`define WDT_EVT_ABORT       2

// ---------------------------------------------------------------------------
// Reset values and timing counts
// ---------------------------------------------------------------------------
`define WDT_CTRL_RESET      8'h00
`define WDT_EVT_RESET_VAL   3'h0
`define WDT_MASK_RESET      3'h0
`define WDT_XTAL_BASE       17'h00200
`define WDT_SCALER_IMMED    4'h8

`endif

//--- src/wdt_pkg.sv
`include "wdt_defines.svh"

package wdt_pkg;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [0:0] {
    LOCKED   = 1'b0,
    UNLOCKED = 1'b1
  } unlock_state_t;

  typedef logic [16:0] tick_count_t;

  // Number of crystal periods in one timeout for a scaler code of 0 to 7.
  function automatic tick_count_t period_ticks(input logic [2:0] code);
    period_ticks = `WDT_XTAL_BASE << code;
  endfunction : period_ticks

endpackage : wdt_pkg

//--- src/wdt_count_if.sv
interface wdt_count_if;
  import wdt_pkg::*;

  logic        tick;
  logic        run;
  logic        restart;
  logic [2:0]  scaler;
  logic        expired;
  tick_count_t count;

  modport ctrl    (output run, output restart, output scaler,
                   input tick, input expired, input count);
  modport counter (input run, input restart, input scaler, input tick,
                   output expired, output count);
  modport ticker  (output tick);
endinterface : wdt_count_if

//--- src/wdt_xtal_tick.sv
module wdt_xtal_tick (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Crystal clock pin
  input  wire logic i_xtal_clk,
  // Tick to the counter
  wdt_count_if.ticker tk
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic tick_q;

  // -------------------------------------------------------------------------
  // Crystal edge detection
  // -------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      tick_q  <= 1'b0;
    end else begin
      sync1_q <= i_xtal_clk;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      tick_q  <= sync2_q & ~prev_q;
    end
  end

  assign tk.tick = tick_q;

endmodule : wdt_xtal_tick

//--- src/wdt_counter.sv
module wdt_counter
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Counter control
  wdt_count_if.counter cnt
);

  tick_count_t count_q;
  logic        expired_q;

  // -------------------------------------------------------------------------
  // Timeout counter
  // -------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_q   <= '0;
      expired_q <= 1'b0;
    end else begin
      expired_q <= 1'b0;
      if (!cnt.run || cnt.restart) begin
        count_q <= '0;
      end else if (cnt.tick) begin
        if (count_q == period_ticks(cnt.scaler) - 17'h00001) begin
          count_q   <= '0;
          expired_q <= 1'b1;
        end else begin
          count_q <= count_q + 17'h00001;
        end
      end
    end
  end

  assign cnt.expired = expired_q;
  assign cnt.count   = count_q;

endmodule : wdt_counter

//--- src/wdt_top.sv
`include "wdt_defines.svh"

module wdt_top
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Crystal clock and supply monitor
  input  wire logic        i_xtal_clk,
  input  wire logic        i_supply_monitor_interrupt,
  // Watchdog outputs
  output logic             o_chip_reset,
  output logic             o_wdt_irq,
  output logic             o_irq
);

  // -------------------------------------------------------------------------
  // Constants
  // -------------------------------------------------------------------------
  localparam logic [7:0] ctrl_rst_val = `WDT_CTRL_RESET;

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  wdt_count_if cif ();

  unlock_state_t unlock_q;
  unlock_state_t unlock_d;
  logic          enable_q;
  logic          status_q;
  logic          resp_irq_q;
  logic [3:0]    scaler_q;
  logic          restart_q;
  logic [2:0]    evt_q;
  logic [2:0]    mask_q;
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;
  logic          chip_reset_q;
  logic          wdt_irq_q;
  logic          irq_q;

  logic          apb_setup;
  logic          apb_done;
  logic          wr_done;
  logic          hit_ctrl;
  logic          hit_evt;
  logic          hit_mask;
  logic          hit_count;
  logic          mapped;
  logic          ctrl_wr;
  logic          ctrl_accept;
  logic          ctrl_abort;
  logic          immed_reset;
  logic          timeout_irq;
  logic          timeout_rst;
  logic          timeout_any;
  logic [2:0]    evt_set;
  logic [2:0]    evt_d;
  logic [7:0]    ctrl_view;
  logic [31:0]   rdata_mux;

  // -------------------------------------------------------------------------
  // Submodules
  // -------------------------------------------------------------------------
  wdt_xtal_tick u_tick (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_xtal_clk (i_xtal_clk),
    .tk         (cif.ticker)
  );

  wdt_counter u_counter (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .cnt      (cif.counter)
  );

  // -------------------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------------------
  // Each register decodes one full word address; anything else is unmapped.
  assign hit_ctrl  = (i_paddr == `WDT_CTRL_OFFSET);
  assign hit_evt   = (i_paddr == `WDT_EVT_OFFSET);
  assign hit_mask  = (i_paddr == `WDT_MASK_OFFSET);
  assign hit_count = (i_paddr == `WDT_COUNT_OFFSET);
  assign mapped    = hit_ctrl | hit_evt | hit_mask | hit_count;

  // The access phase takes one wait state; the transfer completes when the
  // registered ready is seen high together with psel and penable.
  assign apb_setup = i_psel & i_penable & ~pready_q;
  assign apb_done  = i_psel & i_penable & pready_q;
  assign wr_done   = apb_done & i_pwrite;

  // -------------------------------------------------------------------------
  // Control write qualification
  // -------------------------------------------------------------------------
  assign ctrl_wr     = wr_done & hit_ctrl;
  assign ctrl_accept = ctrl_wr & (unlock_q == UNLOCKED);
  assign ctrl_abort  = ctrl_wr & (unlock_q == LOCKED) & ~i_pwdata[`WDT_UNLOCK_BIT];

  // -------------------------------------------------------------------------
  // Timeout decode
  // -------------------------------------------------------------------------
  // Scaler codes of eight and above request a reset at once; reserved codes act alike.
  assign immed_reset = enable_q & scaler_q[3];
  assign timeout_irq = enable_q & ~scaler_q[3] & cif.expired & resp_irq_q;
  assign timeout_rst = (enable_q & ~scaler_q[3] & cif.expired & ~resp_irq_q)
                     | immed_reset;
  assign timeout_any = timeout_irq | timeout_rst;

  // -------------------------------------------------------------------------
  // Counter control
  // -------------------------------------------------------------------------
  // The counter is held at zero while disabled or while an immediate reset is pending.
  assign cif.run     = enable_q & ~scaler_q[3];
  assign cif.restart = restart_q;
  assign cif.scaler  = scaler_q[2:0];

  // -------------------------------------------------------------------------
  // Unlock sequencer
  // -------------------------------------------------------------------------
  // Any completed write ends the unlock window; reads leave it open.
  always_comb begin
    unlock_d = unlock_q;
    unique case (unlock_q)
      LOCKED: begin
        if (ctrl_wr && i_pwdata[`WDT_UNLOCK_BIT]) begin
          unlock_d = UNLOCKED;
        end
      end
      UNLOCKED: begin
        if (wr_done) begin
          unlock_d = LOCKED;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      unlock_q <= LOCKED;
    end else begin
      unlock_q <= unlock_d;
    end
  end

  // -------------------------------------------------------------------------
  // Enable bit
  // -------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      enable_q <= ctrl_rst_val[`WDT_ENABLE_BIT];
    end else if (i_supply_monitor_interrupt || timeout_rst) begin
      enable_q <= 1'b0;
    end else if (ctrl_accept) begin
      enable_q <= i_pwdata[`WDT_ENABLE_BIT];
    end
  end

  // A write of 1 to the enable bit restarts the period even if already set.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= ctrl_accept & i_pwdata[`WDT_ENABLE_BIT];
    end
  end

  // -------------------------------------------------------------------------
  // Timeout status flag
  // -------------------------------------------------------------------------
  // The flag survives the chip reset this block requests, because that reset
  // is an output only and never reaches i_resetn of this block.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_q <= ctrl_rst_val[`WDT_STATUS_BIT];
    end else if (timeout_any) begin
      status_q <= 1'b1;
    end else if (ctrl_accept && !i_pwdata[`WDT_STATUS_BIT]) begin
      status_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Response select and scaler
  // -------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      resp_irq_q <= ctrl_rst_val[`WDT_RESP_BIT];
    end else if (ctrl_accept) begin
      resp_irq_q <= i_pwdata[`WDT_RESP_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scaler_q <= ctrl_rst_val[`WDT_SCALER_MSB:`WDT_SCALER_LSB];
    end else if (ctrl_accept) begin
      scaler_q <= i_pwdata[`WDT_SCALER_MSB:`WDT_SCALER_LSB];
    end
  end

  assign ctrl_view = {scaler_q, resp_irq_q, status_q, enable_q, unlock_q == UNLOCKED};

  // -------------------------------------------------------------------------
  // Watchdog outputs
  // -------------------------------------------------------------------------
  // The watchdog interrupt bypasses the event mask; in interrupt mode the
  // enable bit stays set and the counter keeps cycling as a periodic timer.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdt_irq_q <= 1'b0;
    end else begin
      wdt_irq_q <= timeout_irq;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      chip_reset_q <= 1'b0;
    end else begin
      chip_reset_q <= timeout_rst;
    end
  end

  // -------------------------------------------------------------------------
  // Event and mask registers
  // -------------------------------------------------------------------------
  // A hardware event in the same cycle as a software clear leaves its bit set.
  always_comb begin
    evt_set                  = '0;
    evt_set[`WDT_EVT_TIMEOUT] = timeout_irq;
    evt_set[`WDT_EVT_RESET]   = timeout_rst;
    evt_set[`WDT_EVT_ABORT]   = ctrl_abort;
    evt_d = evt_q;
    if (wr_done && hit_evt) begin
      evt_d = evt_q & ~i_pwdata[2:0];
    end
    evt_d = evt_d | evt_set;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      evt_q <= `WDT_EVT_RESET_VAL;
    end else begin
      evt_q <= evt_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mask_q <= `WDT_MASK_RESET;
    end else if (wr_done && hit_mask) begin
      mask_q <= i_pwdata[2:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(evt_d & mask_q);
    end
  end

  // -------------------------------------------------------------------------
  // APB response
  // -------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= apb_setup;
    end
  end

  // Unmapped addresses answer with an error and read as zero.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= apb_setup & ~mapped;
    end
  end

  // -------------------------------------------------------------------------
  // Read data selection
  // -------------------------------------------------------------------------
  always_comb begin
    rdata_mux = '0;
    if (hit_ctrl) begin
      rdata_mux = {24'h000000, ctrl_view};
    end else if (hit_evt) begin
      rdata_mux = {29'h0000000, evt_q};
    end else if (hit_mask) begin
      rdata_mux = {29'h0000000, mask_q};
    end else if (hit_count) begin
      rdata_mux = {15'h000, cif.count};
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata_q <= '0;
    end else if (apb_setup && !i_pwrite) begin
      prdata_q <= rdata_mux;
    end else if (apb_done) begin
      prdata_q <= '0;
    end
  end

  // -------------------------------------------------------------------------
  // Output assignments
  // -------------------------------------------------------------------------
  assign o_prdata     = prdata_q;
  assign o_pready     = pready_q;
  assign o_pslverr    = pslverr_q;
  assign o_chip_reset = chip_reset_q;
  assign o_wdt_irq    = wdt_irq_q;
  assign o_irq        = irq_q;

endmodule : wdt_top

//--- testbench/wdt_top_assertions.sv
`include "wdt_defines.svh"
module wdt_top_assertions (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_resetn,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Watchdog
  input wire logic        i_supply_monitor_interrupt,
  input wire logic        o_chip_reset,
  input wire logic        o_wdt_irq,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // Tracks the unlock state so that accepted control writes can be told apart.
  logic wr_done;
  logic ctl_wr;
  logic unl_q;
  assign wr_done = i_psel & i_penable & o_pready & i_pwrite;
  assign ctl_wr  = wr_done & (i_paddr == `WDT_CTRL_OFFSET);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      unl_q <= 1'b0;
    end else if (wr_done) begin
      unl_q <= ctl_wr & ~unl_q & i_pwdata[0];
    end
  end

  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  sequence access_s;
    i_psel && i_penable && !o_pready;
  endsequence

  pready_wait_a: assert property (setup_s ##1 access_s |=> o_pready)
    else $error("ready not given after one wait state");
  pready_pulse_a: assert property (o_pready |-> i_psel && i_penable ##1 !o_pready)
    else $error("ready outside access or longer than one cycle");
  slverr_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("slave error without ready");
  prdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data not zero outside a transfer");
  irq_pulse_a: assert property (o_wdt_irq |=> !o_wdt_irq [*8])
    else $error("watchdog interrupt repeated too soon");
  rst_pulse_a: assert property (o_chip_reset |=> !o_chip_reset)
    else $error("chip reset request longer than one cycle");
  rst_quiet_a: assert property (o_chip_reset |=> !o_wdt_irq [*8])
    else $error("interrupt right after watchdog reset");
  immed_rst_a: assert property (ctl_wr && unl_q && i_pwdata[1] && i_pwdata[7] &&
                                !i_supply_monitor_interrupt |-> ##[1:4] o_chip_reset)
    else $error("immediate reset code gave no reset");
  locked_ign_a: assert property (ctl_wr && !unl_q && !i_pwdata[0] && i_pwdata[1] &&
                                 i_pwdata[7] |=> !o_chip_reset [*8])
    else $error("locked control write took effect");
  reset_clean_a: assert property ($rose(i_resetn) |-> !o_chip_reset && !o_wdt_irq && !o_irq)
    else $error("outputs active after reset release");
endmodule : wdt_top_assertions

bind wdt_top wdt_top_assertions chk_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_supply_monitor_interrupt(i_supply_monitor_interrupt), .o_chip_reset(o_chip_reset),
  .o_wdt_irq(o_wdt_irq), .o_irq(o_irq));

//--- testbench/tb_watchdog_timer_control.sv
module tb_watchdog_timer_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic        alarm = 1'b0;
  logic [2:0]  xdiv = 3'h0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_chip_reset;
  logic        o_wdt_irq;
  logic        o_irq;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0;
  int          checks = 0;
  int          n;

  // The crystal pin rises once every 8 clocks.
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) xdiv <= xdiv + 3'h1;

  wdt_top dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_xtal_clk(xdiv[2]),
    .i_supply_monitor_interrupt(alarm), .o_chip_reset(o_chip_reset),
    .o_wdt_irq(o_wdt_irq), .o_irq(o_irq));

  // ---------------------------------------------------------------------------
  // Bus tasks and comparisons
  // ---------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : rng

  task automatic rdx(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rd, exp);
  endtask : rdx

  task automatic ctrl_set(input logic [31:0] v);
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b1, 12'h000, v);
  endtask : ctrl_set

  task automatic wait_ev(input bit rst, input int lim);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while ((rst ? o_chip_reset : o_wdt_irq) !== 1'b1 && n < lim);
  endtask : wait_ev

  task automatic done(input string s);
    $display("test %s end, checks=%0d", s, checks);
  endtask : done

  task automatic wrap_up;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    rdx(12'h000, 32'h0000_0000);
    rdx(12'h004, 32'h0000_0000);
    rdx(12'h00C, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    cmp({31'h0, er}, 32'h0000_0001);
    cmp(rd, 32'h0000_0000);
    done("reset");
    apb(1'b1, 12'h008, 32'h0000_0004);
    apb(1'b1, 12'h000, 32'h0000_0082);
    rdx(12'h000, 32'h0000_0000);
    rdx(12'h004, 32'h0000_0004);
    cmp({31'h0, o_irq}, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_0004);
    rdx(12'h004, 32'h0000_0000);
    cmp({31'h0, o_irq}, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0001);
    rdx(12'h000, 32'h0000_0001);
    apb(1'b1, 12'h008, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0082);
    rdx(12'h000, 32'h0000_0000);
    cmp({31'h0, o_irq}, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_0004);
    done("lock");
    ctrl_set(32'h0000_000A);
    rdx(12'h000, 32'h0000_000A);
    wait_ev(1'b0, 5000);
    rng(n, 4060, 4120);
    wait_ev(1'b0, 5000);
    rng(n, 4096, 4096);
    rdx(12'h000, 32'h0000_000E);
    rdx(12'h004, 32'h0000_0001);
    done("intr");
    repeat (3000) @(posedge i_clk);
    ctrl_set(32'h0000_000A);
    rdx(12'h000, 32'h0000_000A);
    wait_ev(1'b0, 5000);
    rng(n, 4060, 4120);
    ctrl_set(32'h0000_001A);
    wait_ev(1'b0, 9000);
    rng(n, 8160, 8220);
    apb(1'b1, 12'h004, 32'h0000_0001);
    done("refresh");
    ctrl_set(32'h0000_0000);
    rdx(12'h00C, 32'h0000_0000);
    wait_ev(1'b0, 5000);
    rng(n, 5000, 5000);
    done("off");
    ctrl_set(32'h0000_0002);
    wait_ev(1'b1, 5000);
    rng(n, 4060, 4120);
    rdx(12'h000, 32'h0000_0004);
    rdx(12'h004, 32'h0000_0002);
    apb(1'b1, 12'h004, 32'h0000_0002);
    done("wdrst");
    ctrl_set(32'h0000_000A);
    @(posedge i_clk);
    alarm <= 1'b1;
    @(posedge i_clk);
    alarm <= 1'b0;
    rdx(12'h000, 32'h0000_0008);
    done("alarm");
    for (int c = 8; c < 16; c++) begin
      ctrl_set({24'h0, c[3:0], 4'h2});
      wait_ev(1'b1, 8);
      rng(n, 1, 7);
      rdx(12'h000, {24'h0, c[3:0], 4'h4});
    end
    done("immed");
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    rdx(12'h000, 32'h0000_0000);
    done("hwrst");
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge i_clk);
    err_total++;
    wrap_up();
  end
endmodule : tb_watchdog_timer_control
